// ==== verilog/scsc_pkg.sv ====
// Constants and types for the system clock source control block
package scsc_pkg;

    // Register byte offsets on the Wishbone bus
    localparam logic [7:0] OFS_OSC_RUN   = 8'h00;
    localparam logic [7:0] OFS_MAIN_SEL  = 8'h04;
    localparam logic [7:0] OFS_FREQ_SEL  = 8'h08;
    localparam logic [7:0] OFS_SPEED     = 8'h0C;
    localparam logic [7:0] OFS_PIN_MODE  = 8'h10;

    // Field positions
    localparam int BIT_HS_SYS_STOP  = 7;
    localparam int BIT_HS_INT_STOP  = 0;
    localparam int BIT_SRC_STATE    = 5;
    localparam int BIT_SRC_SELECT   = 4;
    localparam int BIT_LOWCLK_EN    = 4;
    localparam int BIT_EXT_CLK_IN   = 7;
    localparam int BIT_XTAL_SELECT  = 6;
    localparam int FREQ_MSB         = 2;

    // Reset values
    localparam logic       RST_HS_SYS_STOP = 1'b1;
    localparam logic       RST_HS_INT_STOP = 1'b0;
    localparam logic       RST_SRC_SELECT  = 1'b0;
    localparam logic       RST_LOWCLK_EN   = 1'b0;
    localparam logic [1:0] RST_PIN_MODE    = 2'h0;

    // Internal oscillator frequency codes
    localparam logic [2:0] FREQ_16M = 3'h0;
    localparam logic [2:0] FREQ_8M  = 3'h1;
    localparam logic [2:0] FREQ_4M  = 3'h2;
    localparam logic [2:0] FREQ_2M  = 3'h3;
    localparam logic [2:0] FREQ_1M  = 3'h4;

    // High-speed pin modes {external clock input, oscillator select}
    localparam logic [1:0] MODE_XTAL = 2'h1;
    localparam logic [1:0] MODE_EXT  = 2'h3;

    // Dead time between old gate off and new gate on
    localparam int CLK_PERIOD_NS = 100;
    localparam int DWELL_NS      = 200;
    localparam int DWELL_CYC     =
        (DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        (DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] DWELL_CNT = 4'(DWELL_CYC);

    // Option byte content; freq is caught after reset, the WDT bits are read live
    typedef struct packed {
        logic       wdt_en;
        logic       wdt_stby_run;
        logic [2:0] freq;
    } scsc_opt_t;

    // Switch sequencer states
    typedef enum logic [2:0] {
        SW_RUN   = 3'h1,
        SW_DRAIN = 3'h2,
        SW_WAIT  = 3'h4
    } scsc_sw_state_t;

    typedef struct packed {
        scsc_sw_state_t state;
        logic [3:0]     cnt;
        logic           cur_hs;
        logic           gate_int;
        logic           gate_hs;
    } scsc_sw_t;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdat;
        logic       hs_sys_osc_stop;
        logic       hs_internal_osc_stop;
        logic       main_clock_source_select;
        logic [1:0] pin_mode;
        logic [2:0] internal_osc_freq_select;
        logic       opt_loaded;
        logic       interval_timer_lowclk_enable;
        logic       int_en;
        logic       xtal_en;
        logic       ext_en;
        logic       ls_en;
    } scsc_main_t;

endpackage

// ==== verilog/scsc_switch.sv ====
// Glitch-free main clock source switch sequencer
`timescale 1ns/1ps
`default_nettype none

module scsc_switch (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Request and source health
    input  wire logic req_hs,
    input  wire logic int_running,
    input  wire logic hs_running,
    // Gates and status
    output logic      gate_int,
    output logic      gate_hs,
    output logic      cur_hs
);

    localparam int DW = scsc_pkg::DWELL_CYC;

    scsc_pkg::scsc_sw_t s_q;
    scsc_pkg::scsc_sw_t s_d;
    logic               tgt_ok;

    always_comb begin
        s_d = s_q;
        tgt_ok = req_hs ? hs_running : int_running;
        case (s_q.state)
            scsc_pkg::SW_RUN: begin
                if (req_hs != s_q.cur_hs) begin
                    // Both gates closed before anything new opens
                    s_d.gate_int = 1'b0;
                    s_d.gate_hs  = 1'b0;
                    s_d.cnt      = scsc_pkg::DWELL_CNT;
                    s_d.state    = scsc_pkg::SW_DRAIN;
                end
            end
            scsc_pkg::SW_DRAIN: begin
                if (s_q.cnt <= 4'h1) begin
                    s_d.state = scsc_pkg::SW_WAIT;
                end
                s_d.cnt = s_q.cnt - 4'h1;
            end
            scsc_pkg::SW_WAIT: begin
                // New source must be running before it is let through
                if (tgt_ok) begin
                    s_d.cur_hs   = req_hs;
                    s_d.gate_hs  = req_hs;
                    s_d.gate_int = !req_hs;
                    s_d.state    = scsc_pkg::SW_RUN;
                end
            end
            default: begin
                s_d.state = scsc_pkg::SW_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // Start-up always on the internal oscillator
            s_q.state    <= scsc_pkg::SW_RUN;
            s_q.cnt      <= 4'h0;
            s_q.cur_hs   <= 1'b0;
            s_q.gate_int <= 1'b1;
            s_q.gate_hs  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign gate_int = s_q.gate_int;
    assign gate_hs  = s_q.gate_hs;
    assign cur_hs   = s_q.cur_hs;

    a_gates_exclusive: assert property (@(posedge clk) disable iff (rst)
        !(s_q.gate_int && s_q.gate_hs))
        else $error("both clock gates open");

    a_gap_before_new: assert property (@(posedge clk) disable iff (rst)
        $rose(s_q.gate_hs) |-> $past(!s_q.gate_int, DW))
        else $error("high-speed gate opened without dead time");

    a_new_src_running: assert property (@(posedge clk) disable iff (rst)
        $rose(s_q.gate_hs) |-> $past(hs_running))
        else $error("gate opened on a stopped source");

    a_state_tracks_gate: assert property (@(posedge clk) disable iff (rst)
        (s_q.gate_hs || s_q.gate_int) |-> (s_q.cur_hs == s_q.gate_hs))
        else $error("source status disagrees with open gate");

endmodule

`default_nettype wire

// ==== verilog/scsc_top.sv ====
// Top of the system clock source control block with Wishbone registers
`timescale 1ns/1ps
`default_nettype none

module scsc_top (
    // Clock and reset
    input  wire logic                SYS_CLK,
    input  wire logic                SYS_RST,
    // Wishbone slave
    input  wire logic                WB_CYC_I,
    input  wire logic                WB_STB_I,
    input  wire logic                WB_WE_I,
    input  wire logic [7:0]          WB_ADR_I,
    input  wire logic [3:0]          WB_SEL_I,
    input  wire logic [31:0]         WB_DAT_I,
    output logic      [31:0]         WB_DAT_O,
    output logic                     WB_ACK_O,
    // Option byte, CPU standby and high-speed oscillator status
    input  wire scsc_pkg::scsc_opt_t OPT_BYTE,
    input  wire logic                STOP_MODE,
    input  wire logic                HALT_MODE,
    input  wire logic                HS_SYS_STABLE,
    // Oscillator controls
    output logic                     HS_INT_OSC_EN,
    output logic      [2:0]          HS_INT_FREQ,
    output logic                     XTAL_OSC_EN,
    output logic                     EXT_CLK_GATE_EN,
    output logic                     LS_OSC_EN,
    // Main clock gates, low-speed clock only reaches WDT and timer
    output logic                     MAIN_GATE_INT,
    output logic                     MAIN_GATE_HS,
    output logic                     MAIN_SRC_STATE
);

    scsc_pkg::scsc_main_t r_q;
    scsc_pkg::scsc_main_t r_d;
    logic                 req;
    logic                 wr;
    logic                 gate_int;
    logic                 gate_hs;
    logic                 cur_hs;
    logic                 hs_running;
    logic                 standby;

    assign req = WB_CYC_I && WB_STB_I && !r_q.ack;
    assign wr  = req && WB_WE_I && WB_SEL_I[0];
    assign hs_running = HS_SYS_STABLE && (r_q.xtal_en || r_q.ext_en);
    assign standby = HALT_MODE || STOP_MODE;

    always_comb begin
        r_d = r_q;
        r_d.ack = req;
        // Option byte frequency is taken once, the cycle after reset release
        if (!r_q.opt_loaded) begin
            r_d.opt_loaded = 1'b1;
            if (OPT_BYTE.freq <= scsc_pkg::FREQ_1M) begin
                r_d.internal_osc_freq_select = OPT_BYTE.freq;
            end
        end
        if (wr) begin
            if (WB_ADR_I == scsc_pkg::OFS_OSC_RUN) begin
                r_d.hs_sys_osc_stop =
                    WB_DAT_I[scsc_pkg::BIT_HS_SYS_STOP];
                r_d.hs_internal_osc_stop =
                    WB_DAT_I[scsc_pkg::BIT_HS_INT_STOP];
            end else if (WB_ADR_I == scsc_pkg::OFS_MAIN_SEL) begin
                r_d.main_clock_source_select =
                    WB_DAT_I[scsc_pkg::BIT_SRC_SELECT];
            end else if (WB_ADR_I == scsc_pkg::OFS_FREQ_SEL) begin
                // Unlisted codes are dropped so the oscillator never
                // sees an undefined rate
                if (WB_DAT_I[scsc_pkg::FREQ_MSB:0] <= scsc_pkg::FREQ_1M)
                begin
                    r_d.internal_osc_freq_select =
                        WB_DAT_I[scsc_pkg::FREQ_MSB:0];
                end
            end else if (WB_ADR_I == scsc_pkg::OFS_SPEED) begin
                r_d.interval_timer_lowclk_enable =
                    WB_DAT_I[scsc_pkg::BIT_LOWCLK_EN];
            end else if (WB_ADR_I == scsc_pkg::OFS_PIN_MODE) begin
                r_d.pin_mode = {WB_DAT_I[scsc_pkg::BIT_EXT_CLK_IN],
                                WB_DAT_I[scsc_pkg::BIT_XTAL_SELECT]};
            end
        end
        r_d.rdat = 8'h00;
        if (req && !WB_WE_I) begin
            if (WB_ADR_I == scsc_pkg::OFS_OSC_RUN) begin
                r_d.rdat[scsc_pkg::BIT_HS_SYS_STOP] = r_q.hs_sys_osc_stop;
                r_d.rdat[scsc_pkg::BIT_HS_INT_STOP] =
                    r_q.hs_internal_osc_stop;
            end else if (WB_ADR_I == scsc_pkg::OFS_MAIN_SEL) begin
                r_d.rdat[scsc_pkg::BIT_SRC_STATE] = cur_hs;
                r_d.rdat[scsc_pkg::BIT_SRC_SELECT] =
                    r_q.main_clock_source_select;
            end else if (WB_ADR_I == scsc_pkg::OFS_FREQ_SEL) begin
                r_d.rdat[scsc_pkg::FREQ_MSB:0] =
                    r_q.internal_osc_freq_select;
            end else if (WB_ADR_I == scsc_pkg::OFS_SPEED) begin
                r_d.rdat[scsc_pkg::BIT_LOWCLK_EN] =
                    r_q.interval_timer_lowclk_enable;
            end else if (WB_ADR_I == scsc_pkg::OFS_PIN_MODE) begin
                r_d.rdat[scsc_pkg::BIT_EXT_CLK_IN]  = r_q.pin_mode[1];
                r_d.rdat[scsc_pkg::BIT_XTAL_SELECT] = r_q.pin_mode[0];
            end
        end
        r_d.int_en = !STOP_MODE && !r_q.hs_internal_osc_stop;
        r_d.xtal_en = (r_q.pin_mode == scsc_pkg::MODE_XTAL) &&
                      !STOP_MODE && !r_q.hs_sys_osc_stop;
        r_d.ext_en = (r_q.pin_mode == scsc_pkg::MODE_EXT) &&
                     !STOP_MODE && !r_q.hs_sys_osc_stop;
        r_d.ls_en = (OPT_BYTE.wdt_en ||
                     r_q.interval_timer_lowclk_enable) &&
                    !(OPT_BYTE.wdt_en &&
                      !r_q.interval_timer_lowclk_enable &&
                      !OPT_BYTE.wdt_stby_run && standby);
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            r_q.ack                          <= 1'b0;
            r_q.rdat                         <= 8'h00;
            r_q.hs_sys_osc_stop              <= scsc_pkg::RST_HS_SYS_STOP;
            r_q.hs_internal_osc_stop         <= scsc_pkg::RST_HS_INT_STOP;
            r_q.main_clock_source_select     <= scsc_pkg::RST_SRC_SELECT;
            r_q.pin_mode                     <= scsc_pkg::RST_PIN_MODE;
            r_q.internal_osc_freq_select     <= scsc_pkg::FREQ_16M;
            r_q.opt_loaded                   <= 1'b0;
            r_q.interval_timer_lowclk_enable <= scsc_pkg::RST_LOWCLK_EN;
            r_q.int_en                       <= 1'b1;
            r_q.xtal_en                      <= 1'b0;
            r_q.ext_en                       <= 1'b0;
            r_q.ls_en                        <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    scsc_switch u_switch (
        .clk         (SYS_CLK),
        .rst         (SYS_RST),
        .req_hs      (r_q.main_clock_source_select),
        .int_running (r_q.int_en),
        .hs_running  (hs_running),
        .gate_int    (gate_int),
        .gate_hs     (gate_hs),
        .cur_hs      (cur_hs)
    );

    assign WB_DAT_O        = {24'h000000, r_q.rdat};
    assign WB_ACK_O        = r_q.ack;
    assign HS_INT_OSC_EN   = r_q.int_en;
    assign HS_INT_FREQ     = r_q.internal_osc_freq_select;
    assign XTAL_OSC_EN     = r_q.xtal_en;
    assign EXT_CLK_GATE_EN = r_q.ext_en;
    assign LS_OSC_EN       = r_q.ls_en;
    assign MAIN_GATE_INT   = gate_int;
    assign MAIN_GATE_HS    = gate_hs;
    assign MAIN_SRC_STATE  = cur_hs;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    a_start_on_int: assert property (
        $fell(SYS_RST) |-> (MAIN_GATE_INT && !MAIN_SRC_STATE))
        else $error("not on internal oscillator after reset");

    a_int_stop: assert property (
        (STOP_MODE || r_q.hs_internal_osc_stop) |=> !HS_INT_OSC_EN)
        else $error("internal oscillator not stopped");

    a_xtal_stop: assert property (
        (STOP_MODE || r_q.hs_sys_osc_stop) |=> !XTAL_OSC_EN)
        else $error("crystal oscillator not stopped");

    a_ext_block: assert property (
        (STOP_MODE || r_q.hs_sys_osc_stop) |=> !EXT_CLK_GATE_EN)
        else $error("external clock not blocked");

    a_freq_write: assert property (
        (wr && WB_ADR_I == scsc_pkg::OFS_FREQ_SEL &&
         WB_DAT_I[2:0] <= scsc_pkg::FREQ_1M && r_q.opt_loaded)
        |=> (HS_INT_FREQ == $past(WB_DAT_I[2:0])))
        else $error("frequency select write lost");

    a_ls_run: assert property (
        (r_q.interval_timer_lowclk_enable ||
         (OPT_BYTE.wdt_en && !standby)) |=> LS_OSC_EN)
        else $error("low-speed oscillator not running");

    a_ls_standby_stop: assert property (
        (OPT_BYTE.wdt_en && !r_q.interval_timer_lowclk_enable &&
         !OPT_BYTE.wdt_stby_run && standby) |=> !LS_OSC_EN)
        else $error("low-speed oscillator ran in standby");

    a_select_reaches: assert property (
        (r_q.main_clock_source_select && hs_running &&
         r_q.int_en) [*8] |-> MAIN_GATE_HS)
        else $error("select did not reach main clock");

endmodule

`default_nettype wire

// ==== verif/scsc_osc_model.sv ====
// Behavioural high-speed oscillator that settles after its enable
`timescale 1ns/1ps
`default_nettype none

module scsc_osc_model #(
    parameter int SETTLE_CYC = 4
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Enables in, settled flag out
    input  wire logic xtal_en,
    input  wire logic ext_en,
    output logic      stable
);
    int cnt;

    // Losing the enable drops the flag on the next clock edge, as a real oscillator does
    always_ff @(posedge clk) begin
        if (rst || !(xtal_en || ext_en)) begin
            cnt    <= 0;
            stable <= 1'b0;
        end else begin
            if (cnt < SETTLE_CYC) begin
                cnt <= cnt + 1;
            end
            stable <= (cnt >= SETTLE_CYC - 1);
        end
    end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the system clock source control block
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                sys_clk = 1'b0;
    logic                sys_rst = 1'b1;
    logic                cyc     = 1'b0;
    logic                stb     = 1'b0;
    logic                we      = 1'b0;
    logic [7:0]          adr     = 8'h00;
    logic [31:0]         wdat    = 32'h0000_0000;
    logic [31:0]         rdat;
    logic                ack;
    scsc_pkg::scsc_opt_t opt     = '{1'b0, 1'b0, scsc_pkg::FREQ_4M};
    logic                stop_m  = 1'b0;
    logic                halt_m  = 1'b0;
    logic                stable;
    logic                int_en, xtal_en, ext_en, ls_en;
    logic [2:0]          freq;
    logic                g_int, g_hs, src;
    logic [7:0]          rd;
    int                  errors     = 0;
    int                  n_compared = 0;

    always #50 sys_clk = ~sys_clk;

    scsc_top scsc_top_i (
        .SYS_CLK(sys_clk), .SYS_RST(sys_rst),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .OPT_BYTE(opt), .STOP_MODE(stop_m), .HALT_MODE(halt_m),
        .HS_SYS_STABLE(stable), .HS_INT_OSC_EN(int_en), .HS_INT_FREQ(freq),
        .XTAL_OSC_EN(xtal_en), .EXT_CLK_GATE_EN(ext_en), .LS_OSC_EN(ls_en),
        .MAIN_GATE_INT(g_int), .MAIN_GATE_HS(g_hs), .MAIN_SRC_STATE(src)
    );

    scsc_osc_model scsc_osc_model_i (
        .clk(sys_clk), .rst(sys_rst), .xtal_en(xtal_en), .ext_en(ext_en),
        .stable(stable)
    );

    task automatic tally_and_finish();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // One classic cycle; the slave's answer delay is not assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h000000, d};
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (ack === 1'b1) break;
        end
        if (k == 20) begin
            errors++;
            tally_and_finish();
        end
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wait_src(input logic exp);
        int k;
        for (k = 0; k < 50 && src !== exp; k++) begin
            @(posedge sys_clk);
        end
        if (k == 50) begin
            errors++;
            tally_and_finish();
        end
        tick(1);
    endtask

    // Both gates high, or the high-speed gate on a dead source, is a glitch
    always @(negedge sys_clk) begin
        if (!sys_rst) begin
            chk("gates", 8'h00, {6'h00, g_int & g_hs, g_hs & ~stable});
        end
    end

    initial begin
        tick(10);
        sys_rst <= 1'b0;
        tick(3);
        chk("freq_opt", 8'(scsc_pkg::FREQ_4M), 8'(freq));
        chk("start_src", 8'h04, {5'h00, g_int, g_hs, src});
        chk("start_osc", 8'h08, {4'h0, int_en, xtal_en, ext_en, ls_en});
        wb(1'b0, scsc_pkg::OFS_OSC_RUN, 8'h00);
        chk("run_reset", 8'h80, rd);
        wb(1'b0, 8'h14, 8'h00);
        chk("unmapped", 8'h00, rd);
        wb(1'b1, scsc_pkg::OFS_FREQ_SEL, 8'h07);
        tick(1);
        chk("freq_bad", 8'(scsc_pkg::FREQ_4M), 8'(freq));
        for (int f = 4; f >= 0; f--) begin
            wb(1'b1, scsc_pkg::OFS_FREQ_SEL, 8'(f));
            tick(1);
            chk("freq_sel", 8'(f), 8'(freq));
        end
        wb(1'b1, scsc_pkg::OFS_OSC_RUN, 8'h81);
        tick(1);
        chk("int_bit", 8'h00, 8'(int_en));
        wb(1'b1, scsc_pkg::OFS_OSC_RUN, 8'h80);
        stop_m <= 1'b1;
        tick(2);
        chk("int_stop", 8'h00, 8'(int_en));
        stop_m <= 1'b0;
        tick(2);
        chk("int_run", 8'h01, 8'(int_en));
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, scsc_pkg::OFS_PIN_MODE, (m == 1) ? 8'hC0 : 8'h40);
            wb(1'b1, scsc_pkg::OFS_OSC_RUN, 8'h00);
            tick(1);
            chk("hs_en", (m == 1) ? 8'h01 : 8'h02, {6'h00, xtal_en, ext_en});
            stop_m <= 1'b1;
            tick(2);
            chk("hs_stop", 8'h00, {6'h00, xtal_en, ext_en});
            stop_m <= 1'b0;
            wb(1'b1, scsc_pkg::OFS_OSC_RUN, 8'h80);
            tick(1);
            chk("hs_bit", 8'h00, {6'h00, xtal_en, ext_en});
        end
        // Target source still stopped: the sequencer must hold off
        wb(1'b1, scsc_pkg::OFS_MAIN_SEL, 8'h10);
        tick(8);
        chk("stalled", 8'h00, {5'h00, g_int, g_hs, src});
        wb(1'b0, scsc_pkg::OFS_MAIN_SEL, 8'h00);
        chk("sel_stalled", 8'h10, rd);
        wb(1'b1, scsc_pkg::OFS_OSC_RUN, 8'h00);
        wait_src(1'b1);
        chk("on_hs", 8'h03, {5'h00, g_int, g_hs, src});
        wb(1'b0, scsc_pkg::OFS_MAIN_SEL, 8'hFF);
        chk("sel_hs", 8'h30, rd);
        wb(1'b1, scsc_pkg::OFS_MAIN_SEL, 8'h00);
        wait_src(1'b0);
        chk("on_int", 8'h04, {5'h00, g_int, g_hs, src});
        wb(1'b0, scsc_pkg::OFS_MAIN_SEL, 8'h00);
        chk("sel_int", 8'h00, rd);
        for (int i = 0; i < 32; i++) begin
            logic e;
            e = (i[0] | i[1]) & ~(i[0] & ~i[1] & ~i[2] & i[3]);
            opt.wdt_en       <= i[0];
            opt.wdt_stby_run <= i[2];
            wb(1'b1, scsc_pkg::OFS_SPEED, {3'h0, i[1], 4'h0});
            halt_m <= i[3] & ~i[4];
            stop_m <= i[3] & i[4];
            tick(2);
            chk("ls_en", 8'(e), 8'(ls_en));
            halt_m <= 1'b0;
            stop_m <= 1'b0;
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
